// ==== core/rst_boot_pkg.sv ====
// package: constants and carriers for the reset and boot vector controller
package rst_boot_pkg;

   // ----------------------------------------
   // widths and encodings
   // ----------------------------------------
   localparam int          ADDR_W         = 16;
   localparam int          PORT_W         = 16;
   localparam int          NUM_SRC        = 10;
   localparam logic [7:0]  BOOT_SIG_VALUE = 8'ha5;
   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [15:0] LOCK_BYTE_ADDR = 16'h7fff;
   localparam logic [15:0] SIG_BYTE_ADDR  = 16'h7ffe;
   localparam logic [15:0] BOOT_VECTOR    = 16'h7e00;
   localparam logic [15:0] PORT_LATCH_RST = 16'hffff;
   localparam logic [15:0] PORT_OD_RST    = 16'h0000;

   // ----------------------------------------
   // source bit positions
   // ----------------------------------------
   localparam int SRC_POR   = 0;
   localparam int SRC_PIN   = 1;
   localparam int SRC_CMP   = 2;
   localparam int SRC_SW    = 3;
   localparam int SRC_VMON  = 4;
   localparam int SRC_WDT   = 5;
   localparam int SRC_MCD   = 6;
   localparam int SRC_FLASH = 7;
   localparam int SRC_RTC   = 8;
   localparam int SRC_RTCOF = 9;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          SYS_CLK_HZ      = 20_000_000;
   localparam int          MIN_HOLD_NS     = 200;
   localparam int          HOLD_CYCLES_RAW = (MIN_HOLD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0]  HOLD_CYCLES     = (HOLD_CYCLES_RAW < 1) ? 8'h01 : 8'(HOLD_CYCLES_RAW);

   typedef enum logic [2:0] {ST_RESET, ST_HOLD, ST_SIG_REQ, ST_SIG_WAIT, ST_RUN} seq_state_e;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic        core_halt;
      logic        irq_disable;
      logic        timer_disable;
      logic        regs_reset;
      logic        por_regs_reset;
   } core_ctrl_s;

   typedef struct packed {
      logic [15:0] latch;
      logic [15:0] push_pull;
      logic        weak_pullup_en;
   } port_ctrl_s;

   typedef struct packed {
      logic        wdt_enable;
      logic        clk_sel_internal;
      logic        pc_load;
      logic [15:0] pc_value;
   } boot_ctrl_s;

endpackage

// ==== core/rst_boot_ctrl.sv ====
// reset and boot vector controller: gathers reset sources and starts the core
`timescale 1ns/1ps
// How it works
// - while in reset the core is held halted, no instructions execute
// - every reset resets module registers; power-on-only bits reset only on power-on or supply-monitor reset
// - reset never touches on-chip RAM; RAM writes and clears are not issued
// - during reset all port latches are 1 and ports open-drain
// - weak pull-ups enabled during reset and stay enabled afterwards
// - supply-monitor or power-on reset drives the reset pin low throughout reset
// - entering reset disables all interrupts and timers
// - leaving reset loads the program counter with the start vector and selects internal oscillator
// - leaving reset enables watchdog; without bootloader fetch starts at zero
// - ten sources can each trigger reset, pin and software included
// - byte below the lock byte is the signature; 0xa5 means bootloader
// - with bootloader present, every reset starts at the bootloader vector
// - with no bootloader, every reset starts at vector zero
// - bootloader vector sits in the last code flash page, erasable
module rst_boot_ctrl
   import rst_boot_pkg::*;
(
   input  wire logic                 sys_clk,              // system clock, 20 MHz
   input  wire logic                 resetn,               // synchronous reset, active low
   input  wire logic [NUM_SRC-1:0]   src_req,              // reset source levels, active high
   input  wire logic [NUM_SRC-1:0]   src_enable,           // enable per source; power-on always enabled
   input  wire logic                 reset_pin_active_low_in, // level seen on the reset pin
   output logic                      reset_pin_active_low_out, // pin drive value, always 0
   output logic                      reset_pin_active_low_oe_n, // low while driving pin low
   output logic [ADDR_W-1:0]         flash_addr,           // flash read address
   output logic                      flash_rd,             // flash read request
   input  wire logic [7:0]           flash_rdata,          // flash read data
   input  wire logic                 flash_rvalid,         // flash read data valid
   output logic                      ram_write_block,      // low: RAM contents untouched by reset
   output core_ctrl_s                core_ctrl,            // core halt and module reset controls
   output port_ctrl_s                port_ctrl,            // port latch and mode controls
   output boot_ctrl_s                boot_ctrl,            // program counter, clock, watchdog
   output logic                      boot_present,         // signature found at last boot
   output logic [NUM_SRC-1:0]        reset_cause           // sources seen in the last reset
);

   // ----------------------------------------
   // source gathering and synchronisation
   // ----------------------------------------
   function automatic logic [NUM_SRC-1:0] gate_src(input logic [NUM_SRC-1:0] req,
                                                   input logic [NUM_SRC-1:0] en);
      logic [NUM_SRC-1:0] g;
      g = req & en;
      g[SRC_POR] = req[SRC_POR];
      return g;
   endfunction

   logic [NUM_SRC-1:0] src_meta;
   logic [NUM_SRC-1:0] src_sync;
   logic               pin_meta;
   logic               pin_sync;
   logic [NUM_SRC-1:0] active;
   logic               any_src;
   logic               pwr_src;
   logic               drive_d1;
   logic               drive_d2;
   logic               pin_own;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         src_meta <= '0;
         src_sync <= '0;
      end else begin
         src_meta <= src_req;
         src_sync <= src_meta;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= reset_pin_active_low_in;
         pin_sync <= pin_meta;
      end
   end

   // own pin drive, delayed like the pin synchroniser, so our own low is never taken as a pin reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         drive_d1 <= 1'b1;
         drive_d2 <= 1'b1;
      end else begin
         drive_d1 <= ~reset_pin_active_low_oe_n;
         drive_d2 <= drive_d1;
      end
   end

   always_comb begin
      pin_own = ~reset_pin_active_low_oe_n | drive_d1 | drive_d2;
      active = gate_src(src_sync, src_enable);
      active[SRC_PIN] = src_enable[SRC_PIN] & (src_sync[SRC_PIN] | (~pin_sync & ~pin_own));
      any_src = |active;
      pwr_src = active[SRC_POR] | active[SRC_VMON];
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   seq_state_e state;
   seq_state_e next_state;
   logic [7:0] hold_cnt;
   logic       pwr_reset;

   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (!any_src) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (any_src) begin
               next_state = ST_RESET;
            end else if (hold_cnt == HOLD_CYCLES) begin
               next_state = ST_SIG_REQ;
            end
         end
         ST_SIG_REQ: begin
            next_state = any_src ? ST_RESET : ST_SIG_WAIT;
         end
         ST_SIG_WAIT: begin
            if (any_src) begin
               next_state = ST_RESET;
            end else if (flash_rvalid) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_src) begin
               next_state = ST_RESET;
            end
         end
         default: next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || state != ST_HOLD) begin
         hold_cnt <= 8'h00;
      end else begin
         hold_cnt <= hold_cnt + 8'h01;
      end
   end

   // power-on-class reset is remembered until the sequencer enters ST_RUN
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pwr_reset <= 1'b1;
      end else if (pwr_src) begin
         pwr_reset <= 1'b1;
      end else if (next_state == ST_RUN) begin
         pwr_reset <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reset_cause <= '0;
      end else if (state == ST_RUN && any_src) begin
         reset_cause <= active;
      end else if (state != ST_RUN) begin
         reset_cause <= reset_cause | active;
      end
   end

   // ----------------------------------------
   // signature read
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flash_rd   <= 1'b0;
         flash_addr <= SIG_BYTE_ADDR;
      end else begin
         flash_rd   <= (next_state == ST_SIG_REQ);
         flash_addr <= SIG_BYTE_ADDR;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         boot_present <= 1'b0;
      end else if (state == ST_SIG_WAIT && flash_rvalid) begin
         boot_present <= (flash_rdata == BOOT_SIG_VALUE);
      end
   end

   // ----------------------------------------
   // outputs to core, ports, pin
   // ----------------------------------------
   logic in_reset_next;
   assign in_reset_next = (next_state != ST_RUN);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      end else begin
         core_ctrl.core_halt      <= in_reset_next;
         core_ctrl.irq_disable    <= in_reset_next;
         core_ctrl.timer_disable  <= in_reset_next;
         core_ctrl.regs_reset     <= in_reset_next;
         core_ctrl.por_regs_reset <= in_reset_next & (pwr_reset | active[SRC_POR]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ram_write_block <= 1'b0;
      end else begin
         ram_write_block <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         port_ctrl <= '{PORT_LATCH_RST, PORT_OD_RST, 1'b1};
      end else if (in_reset_next) begin
         port_ctrl.latch          <= PORT_LATCH_RST;
         port_ctrl.push_pull      <= PORT_OD_RST;
         port_ctrl.weak_pullup_en <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reset_pin_active_low_out  <= 1'b0;
         reset_pin_active_low_oe_n <= 1'b0;
      end else begin
         reset_pin_active_low_out  <= 1'b0;
         reset_pin_active_low_oe_n <= ~(in_reset_next & (pwr_reset | pwr_src));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         boot_ctrl <= '{1'b1, 1'b1, 1'b0, RESET_VECTOR};
      end else begin
         boot_ctrl.pc_load <= (state == ST_SIG_WAIT && flash_rvalid && !any_src);
         if (in_reset_next) begin
            boot_ctrl.wdt_enable       <= 1'b1;
            boot_ctrl.clk_sel_internal <= 1'b1;
         end
         if (state == ST_SIG_WAIT && flash_rvalid) begin
            boot_ctrl.pc_value <= (flash_rdata == BOOT_SIG_VALUE) ? BOOT_VECTOR
                                                                  : RESET_VECTOR;
         end else if (in_reset_next) begin
            boot_ctrl.pc_value <= RESET_VECTOR;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_halt_in_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state != ST_RUN) |-> core_ctrl.core_halt) else $error("core not halted in reset");
   chk_ports_od: assert property (@(posedge sys_clk) disable iff (!resetn)
      (next_state != ST_RUN) |=> (port_ctrl.latch == PORT_LATCH_RST && port_ctrl.push_pull == PORT_OD_RST))
      else $error("ports not released to latch 1 open drain");
   chk_pullup_on: assert property (@(posedge sys_clk) disable iff (!resetn)
      core_ctrl.core_halt |-> port_ctrl.weak_pullup_en) else $error("pullup off in reset");
   chk_pin_power: assert property (@(posedge sys_clk) disable iff (!resetn)
      (pwr_src && next_state != ST_RUN) |=> !reset_pin_active_low_oe_n) else $error("reset pin not driven");
   chk_pin_whole_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(reset_pin_active_low_oe_n) |-> $fell(core_ctrl.core_halt)) else $error("reset pin released early");
   chk_irq_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(core_ctrl.core_halt) |-> (core_ctrl.irq_disable && core_ctrl.timer_disable))
      else $error("irq or timers live in reset");
   chk_boot_vector: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state == ST_SIG_WAIT && flash_rvalid && flash_rdata == BOOT_SIG_VALUE && !any_src)
      |=> (boot_ctrl.pc_load && boot_ctrl.pc_value == BOOT_VECTOR)) else $error("boot vector wrong");
   chk_zero_vector: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state == ST_SIG_WAIT && flash_rvalid && flash_rdata != BOOT_SIG_VALUE && !any_src)
      |=> (boot_ctrl.pc_load && boot_ctrl.pc_value == RESET_VECTOR)) else $error("zero vector wrong");
   chk_stay_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      any_src |=> (state == ST_RESET) ##1 core_ctrl.core_halt) else $error("left reset with source up");
   chk_sig_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
      flash_rd |-> (flash_addr == LOCK_BYTE_ADDR - 16'h0001)) else $error("signature address wrong");
   chk_run_clock: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(core_ctrl.core_halt) |-> (boot_ctrl.wdt_enable && boot_ctrl.clk_sel_internal))
      else $error("watchdog or clock wrong at exit");
   chk_pc_load_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
      boot_ctrl.pc_load |=> !boot_ctrl.pc_load) else $error("pc load longer than one cycle");
   chk_ram_untouched: assert property (@(posedge sys_clk) disable iff (!resetn)
      !ram_write_block) else $error("ram write block raised");

   cov_boot_exit: cover property (@(posedge sys_clk) disable iff (!resetn)
      boot_ctrl.pc_load && boot_ctrl.pc_value == BOOT_VECTOR);
   cov_zero_exit: cover property (@(posedge sys_clk) disable iff (!resetn)
      boot_ctrl.pc_load && boot_ctrl.pc_value == RESET_VECTOR);
   cov_wdt_reset: cover property (@(posedge sys_clk) disable iff (!resetn)
      state == ST_RUN && active[SRC_WDT]);
   cov_pin_reset: cover property (@(posedge sys_clk) disable iff (!resetn)
      state == ST_RUN && active[SRC_PIN]);
   cov_exit_abort: cover property (@(posedge sys_clk) disable iff (!resetn)
      state == ST_SIG_WAIT && any_src);

endmodule

// ==== testbench/flash_sig_model.sv ====
// flash partner model: answers signature reads after a programmable delay
`timescale 1ns/1ps
module flash_sig_model
   import rst_boot_pkg::*;
(
   input  wire logic              sys_clk,      // system clock
   input  wire logic [ADDR_W-1:0] flash_addr,   // read address from the controller
   input  wire logic              flash_rd,     // read request pulse
   input  wire logic [7:0]        sig_byte,     // content of the signature location
   input  wire logic [3:0]        delay,        // cycles from request to answer, at least 1
   output logic      [7:0]        flash_rdata,  // read data
   output logic                   flash_rvalid  // read data valid pulse
);
   logic              busy;
   logic [3:0]        cnt;
   logic [ADDR_W-1:0] addr;

   initial begin
      busy         = 1'b0;
      cnt          = 4'h0;
      addr         = '0;
      flash_rvalid = 1'b0;
      flash_rdata  = 8'h00;
   end

   // a new request replaces one still pending, so a restarted boot is served afresh
   always @(posedge sys_clk) begin
      #1;
      flash_rvalid = 1'b0;
      flash_rdata  = flash_rdata + 8'h5b;  // idle data churns so nothing stale looks valid
      if (flash_rd === 1'b1) begin
         busy = 1'b1;
         cnt  = delay;
         addr = flash_addr;
      end else if (busy) begin
         cnt = cnt - 4'h1;
         if (cnt == 4'h0) begin
            busy         = 1'b0;
            flash_rvalid = 1'b1;
            flash_rdata  = (addr == SIG_BYTE_ADDR) ? sig_byte : ~sig_byte;
         end
      end
   end
endmodule

// ==== testbench/reset_and_boot_vector_control_test.sv ====
// self-checking bench for the reset and boot vector controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module reset_and_boot_vector_control_test
   import rst_boot_pkg::*;
;
   logic                 sys_clk, resetn, ext_pin, pin_wire;
   logic                 reset_pin_active_low_out, reset_pin_active_low_oe_n;
   logic [NUM_SRC-1:0]   src_req, src_enable, reset_cause;
   logic [ADDR_W-1:0]    flash_addr;
   logic                 flash_rd, flash_rvalid, ram_write_block, boot_present;
   logic [7:0]           flash_rdata, sig_byte;
   logic [3:0]           delay;
   core_ctrl_s           core_ctrl;
   port_ctrl_s           port_ctrl;
   boot_ctrl_s           boot_ctrl;
   int                   n_mismatch = 0;
   int                   compares   = 0;
   int                   cycles     = 0;

   // device drive wins over the bench's level on the open-drain reset pin
   assign pin_wire = (reset_pin_active_low_oe_n === 1'b0) ? reset_pin_active_low_out : ext_pin;

   rst_boot_ctrl i_rst_boot_ctrl (.sys_clk(sys_clk), .resetn(resetn), .src_req(src_req),
      .src_enable(src_enable), .reset_pin_active_low_in(pin_wire),
      .reset_pin_active_low_out(reset_pin_active_low_out),
      .reset_pin_active_low_oe_n(reset_pin_active_low_oe_n), .flash_addr(flash_addr),
      .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
      .ram_write_block(ram_write_block), .core_ctrl(core_ctrl), .port_ctrl(port_ctrl),
      .boot_ctrl(boot_ctrl), .boot_present(boot_present), .reset_cause(reset_cause));

   flash_sig_model i_flash_sig_model (.sys_clk(sys_clk), .flash_addr(flash_addr),
      .flash_rd(flash_rd), .sig_byte(sig_byte), .delay(delay), .flash_rdata(flash_rdata),
      .flash_rvalid(flash_rvalid));

   // ----------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         $display("timeout after %0d cycles", cycles);
         give_verdict;
      end
   end

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // ----------------------------------------
   // shared sequences
   // ----------------------------------------
   task automatic in_reset(input logic pwr);
      `CHK("core_halt", 1'b1, core_ctrl.core_halt)
      `CHK("irq_disable", 1'b1, core_ctrl.irq_disable)
      `CHK("timer_disable", 1'b1, core_ctrl.timer_disable)
      `CHK("regs_reset", 1'b1, core_ctrl.regs_reset)
      `CHK("por_regs_reset", pwr, core_ctrl.por_regs_reset)
      `CHK("latch", PORT_LATCH_RST, port_ctrl.latch)
      `CHK("push_pull", PORT_OD_RST, port_ctrl.push_pull)
      `CHK("weak_pullup_en", 1'b1, port_ctrl.weak_pullup_en)
      `CHK("reset_pin_oe_n", ~pwr, reset_pin_active_low_oe_n)
   endtask

   task automatic boot(input logic [7:0] sig);
      int i;
      sig_byte = sig;
      i = 0;
      while (boot_ctrl.pc_load !== 1'b1 && i < 80) begin
         step(1);
         i++;
      end
      `CHK("pc_load", 1'b1, boot_ctrl.pc_load)
      `CHK("pc_value", (sig == BOOT_SIG_VALUE) ? BOOT_VECTOR : RESET_VECTOR, boot_ctrl.pc_value)
      `CHK("boot_present", sig == BOOT_SIG_VALUE, boot_present)
      `CHK("flash_addr", SIG_BYTE_ADDR, flash_addr)
      `CHK("core_halt", 1'b0, core_ctrl.core_halt)
      `CHK("irq_disable", 1'b0, core_ctrl.irq_disable)
      `CHK("timer_disable", 1'b0, core_ctrl.timer_disable)
      `CHK("regs_reset", 1'b0, core_ctrl.regs_reset)
      `CHK("por_regs_reset", 1'b0, core_ctrl.por_regs_reset)
      `CHK("wdt_enable", 1'b1, boot_ctrl.wdt_enable)
      `CHK("clk_sel_internal", 1'b1, boot_ctrl.clk_sel_internal)
      `CHK("reset_pin_oe_n", 1'b1, reset_pin_active_low_oe_n)
      `CHK("ram_write_block", 1'b0, ram_write_block)
      step(1);
      `CHK("pc_load", 1'b0, boot_ctrl.pc_load)
      `CHK("weak_pullup_en", 1'b1, port_ctrl.weak_pullup_en)
      `CHK("latch", PORT_LATCH_RST, port_ctrl.latch)
   endtask

   // raise one source, check the reset state, hold it a while, then let it go
   task automatic enter(input int s);
      int   i;
      logic pwr;
      pwr = (s == SRC_POR) || (s == SRC_VMON);
      if (s == SRC_PIN) ext_pin = 1'b0;
      else src_req[s] = 1'b1;
      i = 0;
      while (core_ctrl.core_halt !== 1'b1 && i < 10) begin
         step(1);
         i++;
      end
      step(1);
      in_reset(pwr);
      step(12);
      `CHK("core_halt held", 1'b1, core_ctrl.core_halt)
      ext_pin    = 1'b1;
      src_req[s] = 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power_on;
      step(3);
      in_reset(1'b1);
      step(5);
      resetn = 1'b1;
      boot(8'ha5);
      $display("test power_on done");
   endtask

   task automatic t_each_source;
      logic [7:0] sigs [10];
      sigs = '{8'ha5, 8'h00, 8'ha4, 8'ha5, 8'ha6, 8'h5a, 8'ha5, 8'hff, 8'h25, 8'ha5};
      for (int s = 0; s < NUM_SRC; s++) begin
         delay = 4'(1 + s % 4);
         src_enable[SRC_POR] = (s != SRC_POR);  // power-on must act even when its enable is low
         enter(s);
         boot(sigs[s]);
         `CHK("reset_cause", 1'b1, reset_cause[s])
         src_enable = '1;
      end
      $display("test each_source done");
   endtask

   task automatic t_masked;
      src_enable[SRC_CMP] = 1'b0;
      src_req[SRC_CMP]    = 1'b1;
      step(10);
      `CHK("core_halt masked", 1'b0, core_ctrl.core_halt)
      src_req[SRC_CMP]    = 1'b0;
      src_enable          = '1;
      $display("test masked done");
   endtask

   task automatic t_abort;
      int i;
      delay = 4'h8;
      enter(SRC_WDT);
      i = 0;
      while (flash_rd !== 1'b1 && i < 20) begin
         step(1);
         i++;
      end
      step(2);
      src_req[SRC_FLASH] = 1'b1;
      step(7);
      `CHK("core_halt restart", 1'b1, core_ctrl.core_halt)
      `CHK("pc_load restart", 1'b0, boot_ctrl.pc_load)
      src_req[SRC_FLASH] = 1'b0;
      boot(8'h3c);
      $display("test abort done");
   endtask

   // reset input pulled while running acts like a power-on reset
   task automatic t_mid_reset;
      resetn = 1'b0;
      step(2);
      in_reset(1'b1);
      resetn = 1'b1;
      boot(8'h00);
      `CHK("reset_cause cleared", 10'h000, reset_cause)
      $display("test mid_reset done");
   endtask

   initial begin
      resetn     = 1'b0;
      src_req    = '0;
      src_enable = '1;
      ext_pin    = 1'b1;
      sig_byte   = 8'ha5;
      delay      = 4'h1;
      t_power_on;
      t_each_source;
      t_masked;
      t_abort;
      t_mid_reset;
      give_verdict;
   end
endmodule
